// ==== design/sr_latch_and_pulse_counter_logic.sv ====
// four set/clear latches with input delays and two pulse counters
// assumes source signals arrive unsynchronised and an apb master
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps

// Overview of operation
// - no active input: latch output holds its value
// - only set drives output high, only clear drives it low
// - clear-wins mode: both active gives low
// - set-wins mode: both active gives high
// - edge mode: most recent rising edge decides the output
// - edge mode: simultaneous rising edges leave output unchanged
// - latch inputs sampled once per 8 ms tick
// - mode codes 0 clear-wins, 1 set-wins, 2 edge; 3 clear-wins
// - set input delayed 0 to 9:59:59.9 in tenths, default zero
// - clear input has its own such delay, default zero
// - running delay timer of each latch is readable
// - four latches, default modes clear, clear, set, edge
// - counter adds one on each rising trigger edge
// - counter held at zero while its clear is high
// - clear beats trigger
// - match output high when count equals match level
// - match level zero keeps output high
// - match level and count span 0 to 10000, level default 0
// - one count store per counter, zero after power-up
// - two counters with own selects, level and output
module sr_latch_and_pulse_counter_logic #(
    parameter int SAMPLE_DIV = srl_pkg::SAMPLE_CYCLES,
    parameter int TENTH_DIV = srl_pkg::TENTH_CYCLES
) (
    input wire logic sys_clk_in, // 10 MHz clock
    input wire logic rst_b_in, // sync reset, active low
    input wire logic [srl_pkg::SRC_W-1:0] src_in, // selectable sources
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [7:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error
    output logic [3:0] latch_out, // latch outputs
    output logic count_match_out_a, // counter a match
    output logic count_match_out_b // counter b match
);
    // ========================================
    // input synchroniser
    logic [srl_pkg::SRC_W-1:0] src_meta_reg;
    logic [srl_pkg::SRC_W-1:0] src_sync_reg;
    logic [srl_pkg::SRC_W:0] src_ext;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
        end else begin
            src_meta_reg <= src_in;
            src_sync_reg <= src_meta_reg;
        end
    end

    // select code 0 is "off"
    assign src_ext = {src_sync_reg, 1'b0};

    // ========================================
    // tick dividers
    logic [31:0] sample_cnt_reg;
    logic [31:0] tenth_cnt_reg;
    logic sample_tick;
    logic tenth_tick;

    assign sample_tick = (sample_cnt_reg == 32'(SAMPLE_DIV - 1));
    assign tenth_tick = (tenth_cnt_reg == 32'(TENTH_DIV - 1));

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            sample_cnt_reg <= '0;
        end else if (sample_tick) begin
            sample_cnt_reg <= '0;
        end else begin
            sample_cnt_reg <= sample_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            tenth_cnt_reg <= '0;
        end else if (tenth_tick) begin
            tenth_cnt_reg <= '0;
        end else begin
            tenth_cnt_reg <= tenth_cnt_reg + 32'h1;
        end
    end

    // ========================================
    // address decode
    logic hit_mode;
    logic hit_set_sel;
    logic hit_clr_sel;
    logic hit_cnt_sel;
    logic hit_trip_a;
    logic hit_trip_b;
    logic hit_dly;
    logic hit_view;
    logic [2:0] dly_rd_idx;
    logic [1:0] view_rd_idx;

    assign hit_mode = (paddr_in == srl_pkg::ADDR_MODE);
    assign hit_set_sel = (paddr_in == srl_pkg::ADDR_SET_SEL);
    assign hit_clr_sel = (paddr_in == srl_pkg::ADDR_CLR_SEL);
    assign hit_cnt_sel = (paddr_in == srl_pkg::ADDR_CNT_SEL);
    assign hit_trip_a = (paddr_in == srl_pkg::ADDR_TRIP_A);
    assign hit_trip_b = (paddr_in == srl_pkg::ADDR_TRIP_B);
    assign hit_dly = (paddr_in >= srl_pkg::ADDR_DLY_BASE) &&
        (paddr_in < srl_pkg::ADDR_VIEW_BASE) && (paddr_in[1:0] == 2'h0);
    assign hit_view = (paddr_in >= srl_pkg::ADDR_VIEW_BASE) &&
        (paddr_in < srl_pkg::ADDR_TRIP_A) && (paddr_in[1:0] == 2'h0);
    // set delays 0x10..0x1C land on 0..3, clear delays 0x20..0x2C on 4..7
    assign dly_rd_idx = {paddr_in[5], paddr_in[3:2]};
    assign view_rd_idx = paddr_in[3:2];

    // ========================================
    // configuration registers
    logic [7:0] mode_reg;
    logic [15:0] set_sel_reg;
    logic [15:0] clr_sel_reg;
    logic [15:0] cnt_sel_reg;
    logic [srl_pkg::DLY_W-1:0] dly_cfg_reg [8];
    logic [srl_pkg::CNT_W-1:0] trip_reg [2];
    logic wr_en;
    logic [srl_pkg::DLY_W-1:0] wr_dly;
    logic [srl_pkg::CNT_W-1:0] wr_trip;

    assign wr_en = psel_in && penable_in && pwrite_in;
    // writes above the range clamp to the top value
    assign wr_dly = (pwdata_in[31:0] > 32'(srl_pkg::DELAY_MAX)) ?
        srl_pkg::DELAY_MAX : pwdata_in[srl_pkg::DLY_W-1:0];
    assign wr_trip = (pwdata_in[31:0] > 32'(srl_pkg::COUNT_MAX)) ?
        srl_pkg::COUNT_MAX : pwdata_in[srl_pkg::CNT_W-1:0];

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            mode_reg <= srl_pkg::MODE_RST;
            set_sel_reg <= srl_pkg::SEL_RST;
            clr_sel_reg <= srl_pkg::SEL_RST;
            cnt_sel_reg <= srl_pkg::SEL_RST;
        end else if (wr_en) begin
            if (hit_mode) begin
                mode_reg <= pwdata_in[7:0];
            end
            if (hit_set_sel) begin
                set_sel_reg <= pwdata_in[15:0];
            end
            if (hit_clr_sel) begin
                clr_sel_reg <= pwdata_in[15:0];
            end
            if (hit_cnt_sel) begin
                cnt_sel_reg <= pwdata_in[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            trip_reg[0] <= srl_pkg::TRIP_RST;
            trip_reg[1] <= srl_pkg::TRIP_RST;
        end else if (wr_en) begin
            if (hit_trip_a) begin
                trip_reg[0] <= wr_trip;
            end
            if (hit_trip_b) begin
                trip_reg[1] <= wr_trip;
            end
        end
    end

    // ========================================
    // delayed latch inputs: 0..3 set, 4..7 clear
    logic [7:0] raw_in;
    logic [7:0] dly_q_reg;
    logic [srl_pkg::DLY_W-1:0] tmr_reg [8];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_dly
            always_ff @(posedge sys_clk_in) begin
                if (!rst_b_in) begin
                    dly_cfg_reg[gi] <= srl_pkg::DLY_RST;
                end else if (wr_en &&
                    paddr_in == srl_pkg::ADDR_DLY_BASE + 8'(4 * gi)) begin
                    dly_cfg_reg[gi] <= wr_dly;
                end
            end

            if (gi < 4) begin : g_set
                assign raw_in[gi] = src_ext[set_sel_reg[4*gi +: 4]];
            end else begin : g_clr
                assign raw_in[gi] = src_ext[clr_sel_reg[4*(gi-4) +: 4]];
            end

            // timer runs while the input differs from its delayed copy
            // zero delay: the copy follows at the next sample tick
            always_ff @(posedge sys_clk_in) begin
                if (!rst_b_in) begin
                    dly_q_reg[gi] <= 1'b0;
                    tmr_reg[gi] <= '0;
                end else if (raw_in[gi] == dly_q_reg[gi]) begin
                    tmr_reg[gi] <= '0;
                end else if (sample_tick &&
                    tmr_reg[gi] >= dly_cfg_reg[gi]) begin
                    dly_q_reg[gi] <= raw_in[gi];
                    tmr_reg[gi] <= '0;
                end else if (tenth_tick &&
                    tmr_reg[gi] < srl_pkg::DELAY_MAX) begin
                    tmr_reg[gi] <= tmr_reg[gi] + 19'h1;
                end
            end
        end
    endgenerate

    // ========================================
    // latches
    logic [3:0] set_prev_reg;
    logic [3:0] clr_prev_reg;
    logic [3:0] q_reg;
    logic [srl_pkg::DLY_W-1:0] view [4];

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            set_prev_reg <= '0;
            clr_prev_reg <= '0;
        end else if (sample_tick) begin
            set_prev_reg <= dly_q_reg[3:0];
            clr_prev_reg <= dly_q_reg[7:4];
        end
    end

    generate
        for (gi = 0; gi < 4; gi++) begin : g_latch
            logic s;
            logic c;
            logic s_rise;
            logic c_rise;
            srl_pkg::latch_mode_t mode;

            assign s = dly_q_reg[gi];
            assign c = dly_q_reg[gi+4];
            assign s_rise = s && !set_prev_reg[gi];
            assign c_rise = c && !clr_prev_reg[gi];
            assign mode = srl_pkg::latch_mode_t'(mode_reg[2*gi +: 2]);
            assign view[gi] = (tmr_reg[gi] != '0) ? tmr_reg[gi] :
                tmr_reg[gi+4];

            always_ff @(posedge sys_clk_in) begin
                if (!rst_b_in) begin
                    q_reg[gi] <= 1'b0;
                end else if (sample_tick) begin
                    if (mode == srl_pkg::MODE_EDGE) begin
                        if (s_rise && !c_rise) begin
                            q_reg[gi] <= 1'b1;
                        end else if (c_rise && !s_rise) begin
                            q_reg[gi] <= 1'b0;
                        end
                        // both rising: hold
                    end else if (s && !c) begin
                        q_reg[gi] <= 1'b1;
                    end else if (c && !s) begin
                        q_reg[gi] <= 1'b0;
                    end else if (s && c) begin
                        // code 3 treated as clear-wins
                        q_reg[gi] <= (mode == srl_pkg::MODE_SET_WINS);
                    end
                    // neither: hold
                end
            end
        end
    endgenerate

    assign latch_out = q_reg;

    // ========================================
    // counters
    logic [1:0] trig_prev_reg;
    logic [srl_pkg::CNT_W-1:0] count_reg [2];
    logic [1:0] match;
    srl_pkg::counter_in_t cin [2];

    generate
        for (gi = 0; gi < 2; gi++) begin : g_cnt
            assign cin[gi].trig = src_ext[cnt_sel_reg[8*gi +: 4]];
            assign cin[gi].clr = src_ext[cnt_sel_reg[8*gi+4 +: 4]];
            assign match[gi] = (trip_reg[gi] == '0) ||
                (count_reg[gi] == trip_reg[gi]);
            // trigger edge judged against the previous sample

            always_ff @(posedge sys_clk_in) begin
                if (!rst_b_in) begin
                    trig_prev_reg[gi] <= 1'b0;
                    count_reg[gi] <= '0;
                end else if (sample_tick) begin
                    trig_prev_reg[gi] <= cin[gi].trig;
                    if (cin[gi].clr) begin
                        count_reg[gi] <= '0;
                    end else if (cin[gi].trig && !trig_prev_reg[gi] &&
                        count_reg[gi] < srl_pkg::COUNT_MAX) begin
                        count_reg[gi] <= count_reg[gi] + 14'h1;
                    end
                end
            end
        end
    endgenerate

    assign count_match_out_a = match[0];
    assign count_match_out_b = match[1];

    // ========================================
    // apb read path, registered in the setup phase
    logic [31:0] rd_next;
    logic err_next;
    logic [31:0] rdata_reg;
    logic err_reg;

    always_comb begin
        rd_next = 32'h0000_0000;
        err_next = 1'b0;
        if (hit_dly) begin
            rd_next = 32'(dly_cfg_reg[dly_rd_idx]);
        end else if (hit_view) begin
            rd_next = 32'(view[view_rd_idx]);
            err_next = pwrite_in;
        end else begin
            unique case (paddr_in)
                srl_pkg::ADDR_MODE: rd_next = 32'(mode_reg);
                srl_pkg::ADDR_SET_SEL: rd_next = 32'(set_sel_reg);
                srl_pkg::ADDR_CLR_SEL: rd_next = 32'(clr_sel_reg);
                srl_pkg::ADDR_CNT_SEL: rd_next = 32'(cnt_sel_reg);
                srl_pkg::ADDR_TRIP_A: rd_next = 32'(trip_reg[0]);
                srl_pkg::ADDR_TRIP_B: rd_next = 32'(trip_reg[1]);
                srl_pkg::ADDR_COUNT_A: begin
                    rd_next = 32'(count_reg[0]);
                    err_next = pwrite_in;
                end
                srl_pkg::ADDR_COUNT_B: begin
                    rd_next = 32'(count_reg[1]);
                    err_next = pwrite_in;
                end
                srl_pkg::ADDR_STATUS: begin
                    rd_next = {26'h0, match, q_reg};
                    err_next = pwrite_in;
                end
                default: err_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (psel_in && !penable_in) begin
            // frozen for the access phase that follows
            rdata_reg <= pwrite_in ? 32'h0000_0000 : rd_next;
            err_reg <= err_next;
        end
    end

    assign prdata_out = rdata_reg;
    assign pslverr_out = err_reg && psel_in && penable_in;
    assign pready_out = psel_in && penable_in;
endmodule

// ==== design/srl_pkg.sv ====
// constants and types for the sr latch and pulse counter block
// assumes a 10 MHz system clock and an apb register bus
package srl_pkg;
    // ========================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SAMPLE_TIME_MS = 8;
    localparam int TENTH_TIME_MS = 100;
    localparam int SAMPLE_CYCLES = SAMPLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TENTH_CYCLES = TENTH_TIME_MS * 1000000 / CLK_PERIOD_NS;
    // ========================================
    // widths and limits
    localparam int DLY_W = 19;
    localparam int CNT_W = 14;
    localparam int SEL_W = 4;
    localparam int SRC_W = 15;
    localparam logic [DLY_W-1:0] DELAY_MAX = 19'h57E3F;
    localparam logic [CNT_W-1:0] COUNT_MAX = 14'h2710;
    // ========================================
    // register byte addresses
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_SET_SEL = 8'h04;
    localparam logic [7:0] ADDR_CLR_SEL = 8'h08;
    localparam logic [7:0] ADDR_CNT_SEL = 8'h0C;
    localparam logic [7:0] ADDR_DLY_BASE = 8'h10;
    localparam logic [7:0] ADDR_VIEW_BASE = 8'h30;
    localparam logic [7:0] ADDR_TRIP_A = 8'h40;
    localparam logic [7:0] ADDR_TRIP_B = 8'h44;
    localparam logic [7:0] ADDR_COUNT_A = 8'h48;
    localparam logic [7:0] ADDR_COUNT_B = 8'h4C;
    localparam logic [7:0] ADDR_STATUS = 8'h50;
    // ========================================
    // reset values
    localparam logic [7:0] MODE_RST = 8'h90;
    localparam logic [15:0] SEL_RST = 16'h0000;
    localparam logic [DLY_W-1:0] DLY_RST = 19'h00000;
    localparam logic [CNT_W-1:0] TRIP_RST = 14'h0000;
    // ========================================
    // types
    typedef enum logic [1:0] {
        MODE_CLEAR_WINS = 2'h0,
        MODE_SET_WINS = 2'h1,
        MODE_EDGE = 2'h2
    } latch_mode_t;
    typedef struct packed {
        logic trig;
        logic clr;
    } counter_in_t;
endpackage

// ==== tb/src_model.sv ====
// model of the internal signal sources feeding the block
// assumes the caller runs its tasks from one process at a time
`timescale 1ns/1ps
module src_model #(
    parameter int HOLD = 64
) (
    input wire logic clk_in, // system clock
    output logic [14:0] src_out // source levels
);
    initial src_out = 15'h0000;
    task automatic drive(input logic [14:0] v);
        @(posedge clk_in);
        src_out <= v;
    endtask
    // one trigger pulse, period kept within the counting rate
    task automatic pulse(input int b);
        @(posedge clk_in);
        src_out[b] <= 1'b1;
        repeat (HOLD) @(posedge clk_in);
        src_out[b] <= 1'b0;
        repeat (HOLD) @(posedge clk_in);
    endtask
endmodule

// ==== tb/srl_checker_asserts.sv ====
// port-level checker for the latch and pulse counter block
// assumes srl_pkg is compiled first and a bind attaches it
`timescale 1ns/1ps
module srl_checker #(
    parameter int SAMPLE_DIV = srl_pkg::SAMPLE_CYCLES
) (
    input wire logic sys_clk_in, // clock
    input wire logic rst_b_in, // sync reset
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb write
    input wire logic [7:0] paddr_in, // apb address
    input wire logic [31:0] pwdata_in, // apb wdata
    input wire logic [31:0] prdata_out, // apb rdata
    input wire logic pready_out, // apb ready
    input wire logic pslverr_out, // apb error
    input wire logic [3:0] latch_out, // latches
    input wire logic count_match_out_a, // match a
    input wire logic count_match_out_b // match b
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic acc;
    logic ro_hit;
    logic lvl_a_zero;
    logic lvl_b_zero;
    int gap_q;
    assign acc = psel_in && penable_in;
    assign ro_hit = paddr_in[7:4] == 4'h3 || paddr_in == 8'h48
        || paddr_in == 8'h4C || paddr_in == 8'h50;
    // ========================================
    // helper: level-zero tracking and latch change spacing
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            lvl_a_zero <= 1'b1;
            lvl_b_zero <= 1'b1;
        end else if (acc && pwrite_in) begin
            if (paddr_in == srl_pkg::ADDR_TRIP_A)
                lvl_a_zero <= pwdata_in == 32'h0;
            if (paddr_in == srl_pkg::ADDR_TRIP_B)
                lvl_b_zero <= pwdata_in == 32'h0;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in)
            gap_q <= 0;
        else if ($changed(latch_out))
            gap_q <= 0;
        else if (gap_q < SAMPLE_DIV)
            gap_q <= gap_q + 1;
    end
    // ========================================
    // assertions
    chk_ready_access: assert property (pready_out == acc)
        else $error("pready does not follow access phase");
    chk_err_in_access: assert property (pslverr_out |-> acc)
        else $error("pslverr outside access phase");
    chk_unmapped_read:
        assert property (acc && !pwrite_in && paddr_in > 8'h50
            |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped read not refused");
    chk_ro_write:
        assert property (acc && pwrite_in && ro_hit |-> pslverr_out)
        else $error("read-only write not refused");
    chk_mapped_read:
        assert property (acc && !pwrite_in && paddr_in <= 8'h50
            && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
        else $error("mapped read refused");
    chk_match_zero_a:
        assert property (lvl_a_zero |-> count_match_out_a)
        else $error("match a low with level zero");
    chk_match_zero_b:
        assert property (lvl_b_zero |-> count_match_out_b)
        else $error("match b low with level zero");
    chk_latch_tick:
        assert property ($changed(latch_out) |-> gap_q >= SAMPLE_DIV - 1)
        else $error("latch changed between sample ticks");
    chk_reset_latch:
        assert property ($past(!rst_b_in) |-> latch_out == 4'h0)
        else $error("latch not cleared by reset");
    cover property (acc && pwrite_in);
    cover property (acc && pslverr_out);
    cover property ($rose(count_match_out_a));
endmodule

// ==== tb/tb.sv ====
// testbench for the latch and pulse counter block
// assumes srl_pkg, the design, checker and source model are compiled
`timescale 1ns/1ps
module tb;
    logic sys_clk_in;
    logic rst_b_in;
    logic psel_in;
    logic penable_in;
    logic pwrite_in;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in;
    logic [14:0] src_in;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [3:0] latch_out;
    logic count_match_out_a;
    logic count_match_out_b;
    logic [31:0] r;
    logic e;
    int n_fail = 0;
    int checks = 0;
    initial sys_clk_in = 1'b0;
    always #50 sys_clk_in = ~sys_clk_in;
    src_model src_u (
        .clk_in(sys_clk_in),
        .src_out(src_in)
    );
    sr_latch_and_pulse_counter_logic #(
        .SAMPLE_DIV(8),
        .TENTH_DIV(20)
    ) dut_u (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .src_in(src_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .latch_out(latch_out), .count_match_out_a(count_match_out_a),
        .count_match_out_b(count_match_out_b)
    );
    // ========================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        @(posedge sys_clk_in);
        while (pready_out !== 1'b1) begin
            n++;
            if (n > 16) begin
                n_fail++;
                tally_and_finish();
            end
            @(posedge sys_clk_in);
        end
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic x);
        xfer(a, 1'b1, d);
        chk({31'h0, e}, {31'h0, x});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v,
        input logic x);
        xfer(a, 1'b0, 32'h0);
        chk(r, v);
        chk({31'h0, e}, {31'h0, x});
    endtask
    task automatic step(input logic [14:0] v, input logic [3:0] x);
        src_u.drive(v);
        repeat (40) @(posedge sys_clk_in);
        chk({28'h0, latch_out}, {28'h0, x});
    endtask
    // ========================================
    // main sequence
    initial begin
        rst_b_in <= 1'b0;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        pwrite_in <= 1'b0;
        paddr_in <= 8'h00;
        pwdata_in <= 32'h0;
        repeat (3) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        rd(srl_pkg::ADDR_MODE, 32'h90, 1'b0);
        rd(8'h10, 32'h0, 1'b0);
        rd(8'h20, 32'h0, 1'b0);
        rd(srl_pkg::ADDR_TRIP_A, 32'h0, 1'b0);
        rd(srl_pkg::ADDR_COUNT_B, 32'h0, 1'b0);
        rd(srl_pkg::ADDR_STATUS, 32'h30, 1'b0);
        rd(8'h60, 32'h0, 1'b1);
        wr(srl_pkg::ADDR_COUNT_A, 32'h5, 1'b1);
        rd(srl_pkg::ADDR_COUNT_A, 32'h0, 1'b0);
        wr(8'h10, 32'hFFFFF, 1'b0);
        rd(8'h10, {13'h0, srl_pkg::DELAY_MAX}, 1'b0);
        rd(8'h20, 32'h0, 1'b0);
        wr(8'h10, 32'h0, 1'b0);
        $display("test registers done");
        wr(srl_pkg::ADDR_MODE, 32'hA4, 1'b0);
        wr(srl_pkg::ADDR_SET_SEL, 32'h7531, 1'b0);
        wr(srl_pkg::ADDR_CLR_SEL, 32'h8642, 1'b0);
        step(15'h55, 4'hF);
        step(15'hFF, 4'h2);
        step(15'h00, 4'h2);
        step(15'hAA, 4'h0);
        step(15'h55, 4'hF);
        step(15'h00, 4'hF);
        step(15'hC0, 4'hF);
        rd(srl_pkg::ADDR_STATUS, 32'h3F, 1'b0);
        $display("test latch modes done");
        wr(8'h20, 32'h3, 1'b0);
        step(15'h02, 4'hF);
        xfer(8'h30, 1'b0, 32'h0);
        chk({31'h0, r >= 32'h1 && r <= 32'h3}, 32'h1);
        repeat (40) @(posedge sys_clk_in);
        step(15'h02, 4'hE);
        $display("test delay done");
        wr(srl_pkg::ADDR_CNT_SEL, 32'hCBA9, 1'b0);
        wr(srl_pkg::ADDR_TRIP_A, 32'h3, 1'b0);
        src_u.pulse(8);
        src_u.pulse(8);
        rd(srl_pkg::ADDR_COUNT_A, 32'h2, 1'b0);
        chk({31'h0, count_match_out_a}, 32'h0);
        src_u.pulse(8);
        chk({31'h0, count_match_out_a}, 32'h1);
        src_u.pulse(8);
        rd(srl_pkg::ADDR_COUNT_A, 32'h4, 1'b0);
        chk({31'h0, count_match_out_a}, 32'h0);
        src_u.drive(15'h0200);
        repeat (40) @(posedge sys_clk_in);
        rd(srl_pkg::ADDR_COUNT_A, 32'h0, 1'b0);
        src_u.pulse(8);
        rd(srl_pkg::ADDR_COUNT_A, 32'h0, 1'b0);
        src_u.drive(15'h0000);
        wr(srl_pkg::ADDR_TRIP_B, 32'h1, 1'b0);
        @(posedge sys_clk_in);
        chk({31'h0, count_match_out_b}, 32'h0);
        src_u.pulse(8);
        src_u.pulse(10);
        rd(srl_pkg::ADDR_COUNT_A, 32'h1, 1'b0);
        rd(srl_pkg::ADDR_COUNT_B, 32'h1, 1'b0);
        chk({31'h0, count_match_out_b}, 32'h1);
        wr(srl_pkg::ADDR_TRIP_A, 32'hFFFF, 1'b0);
        rd(srl_pkg::ADDR_TRIP_A, 32'h2710, 1'b0);
        $display("test counters done");
        @(posedge sys_clk_in);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        rd(srl_pkg::ADDR_COUNT_A, 32'h0, 1'b0);
        rd(srl_pkg::ADDR_MODE, 32'h90, 1'b0);
        chk({31'h0, count_match_out_b}, 32'h1);
        chk({28'h0, latch_out}, 32'h0);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule
bind sr_latch_and_pulse_counter_logic srl_checker #(.SAMPLE_DIV(SAMPLE_DIV))
    chk_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .latch_out(latch_out), .count_match_out_a(count_match_out_a),
    .count_match_out_b(count_match_out_b));
